// >>> verilog/dual_byte_timer_pwm.sv
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Prescaler and low counter run only while the run bit is one.
// - Clock select picks system clock, RC oscillator, oscillator A or B.
// - Prescaler pulses on equal to divider value, clears on that or stop.
// - Low counter advances only on prescaler match pulses.
// - Match clears low counter in modes 1, 3, 4, 5, 7, high counter in 5, 7; sixteen-bit mode needs both halves equal.
// - High counter stops with run low, and in modes 010 and 011.
// - High counter counts low overflow in mode 000, system clock otherwise.
// - Match buffer follows data while stopped, reloads when count reaches zero.
// - Low waveform stays low when stopped and in modes 0, 4, 5.
// - Low waveform toggles on each low match in modes 1, 3, 7.
// - Low waveform set on overflow, cleared on match in modes 2, 6.
// - High waveform stays low when stopped and in modes 0, 2, 3.
// - High waveform toggles on each high match in modes 5, 7.
// - High waveform set on overflow, cleared on match in modes 1, 4, 6.
// - Bit 7 of control reads soft flag AND soft enable.
// - Soft flag and soft enable both one raise the interrupt.
// - Clearing run stops at count zero; buffers follow match data.
// - Match flag set when low count becomes zero, in mode 000 only on the sixteen-bit match; software clears it.
// - Match flag and match enable both one raise the interrupt.
// - Mode field bits 7 to 5 select one of eight combinations.
// - Prescaler period is divider value plus one count clocks.
// - Sixteen-bit period is combined match plus one times divider plus one.
module dual_byte_timer_pwm
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic stb_i,
  input wire logic cyc_i,
  output logic ack_o,
  input wire logic rc_osc_i,
  input wire logic external_clock_a_i,
  input wire logic external_clock_b_i,
  output logic low_waveform_output_o,
  output logic high_waveform_output_o,
  output logic irq_o
);

  typedef struct packed {
    logic [7:0] low_match_data;
    logic [7:0] high_match_data;
    logic soft_irq_flag;
    logic soft_irq_enable;
    logic [1:0] clock_source_select;
    logic run;
    logic match_flag;
    logic match_irq_enable;
    logic [timer_pkg::MODE_WIDTH-1:0] mode;
    logic [timer_pkg::DIV_WIDTH-1:0] divider_compare_value;
    logic [timer_pkg::DIV_WIDTH-1:0] prescaler;
    logic low_wave;
    logic high_wave;
    logic irq;
    logic ack;
    logic [31:0] rdata;
  } timer_state_t;

  timer_state_t state_reg;
  timer_state_t state_next;

  logic rc_rise;
  logic ext_a_rise;
  logic ext_b_rise;
  logic source_tick;
  logic prescale_match;
  logic high_run;
  logic high_tick;
  logic wide_mode;
  logic wide_match;
  logic low_clear_on_match;
  logic high_clear_on_match;
  logic [7:0] low_count;
  logic [7:0] high_count;
  logic low_equal;
  logic high_equal;
  logic low_hit;
  logic high_hit;
  logic low_wrap;
  logic high_wrap;
  logic low_zero;
  logic high_zero;
  logic bus_request;
  logic bus_write;
  logic [29:0] word_index;
  logic [7:0] control_view;
  logic [7:0] divider_view;

  // Oscillator pins are asynchronous to the system clock, so each is synchronised
  // and reduced to a one-cycle pulse per rising edge before it can drive counting.
  edge_sync rc_sync
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(rc_osc_i),
    .rise_o(rc_rise)
  );

  edge_sync ext_a_sync
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(external_clock_a_i),
    .rise_o(ext_a_rise)
  );

  edge_sync ext_b_sync
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(external_clock_b_i),
    .rise_o(ext_b_rise)
  );

  always_comb
  begin
    case (timer_pkg::clock_select_t'(state_reg.clock_source_select))
      timer_pkg::CLOCK_SOURCE_SELECT_SYSTEM: source_tick = 1'b1;
      timer_pkg::CLOCK_SOURCE_SELECT_RC: source_tick = rc_rise;
      timer_pkg::CLOCK_SOURCE_SELECT_EXT_A: source_tick = ext_a_rise;
      timer_pkg::CLOCK_SOURCE_SELECT_EXT_B: source_tick = ext_b_rise;
      default: source_tick = 1'b0;
    endcase
  end

  assign prescale_match = state_reg.run & source_tick
                          & (state_reg.prescaler == state_reg.divider_compare_value);

  assign wide_mode = (state_reg.mode == timer_pkg::MODE_TIMER16);

  assign wide_match = wide_mode & prescale_match & low_equal & high_equal;

  always_comb
  begin
    low_clear_on_match = 1'b1;
    high_clear_on_match = 1'b0;
    high_run = state_reg.run;
    high_tick = 1'b1;
    case (timer_pkg::timer_mode_t'(state_reg.mode))
      timer_pkg::MODE_TIMER16:
      begin
        low_clear_on_match = 1'b0;
        high_tick = low_wrap;
      end
      timer_pkg::MODE_PWM_ONLY:
      begin
        low_clear_on_match = 1'b0;
        high_run = 1'b0;
      end
      timer_pkg::MODE_TOGGLE_ONLY: high_run = 1'b0;
      timer_pkg::MODE_PWM_PWM: low_clear_on_match = 1'b0;
      timer_pkg::MODE_TIMER_TOGGLE,
      timer_pkg::MODE_TOGGLE_TOGGLE:
      begin
        high_clear_on_match = 1'b1;
      end
      default: low_clear_on_match = 1'b1;
    endcase
  end

  byte_counter #(.W(8)) low_half
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(state_reg.run),
    .tick_i(prescale_match),
    .clear_on_match_i(low_clear_on_match),
    .force_clear_i(wide_match),
    .match_data_i(state_reg.low_match_data),
    .count_o(low_count),
    .equal_o(low_equal),
    .hit_o(low_hit),
    .wrap_o(low_wrap),
    .zero_o(low_zero)
  );

  byte_counter #(.W(8)) high_half
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(high_run),
    .tick_i(high_tick),
    .clear_on_match_i(high_clear_on_match),
    .force_clear_i(wide_match),
    .match_data_i(state_reg.high_match_data),
    .count_o(high_count),
    .equal_o(high_equal),
    .hit_o(high_hit),
    .wrap_o(high_wrap),
    .zero_o(high_zero)
  );

  assign word_index = adr_i[31:timer_pkg::ADDR_LSB];
  assign bus_request = cyc_i & stb_i & ~state_reg.ack;
  assign bus_write = bus_request & we_i & sel_i[0];

  always_comb
  begin
    control_view = timer_pkg::RESET_BYTE;
    control_view[timer_pkg::CTL_SOFT_STATE] = state_reg.soft_irq_flag
                                              & state_reg.soft_irq_enable;
    control_view[timer_pkg::CTL_SOFT_FLAG] = state_reg.soft_irq_flag;
    control_view[timer_pkg::CTL_SOFT_ENABLE] = state_reg.soft_irq_enable;
    control_view[timer_pkg::CTL_CLOCK_SOURCE_SELECT_LSB +: 2] = state_reg.clock_source_select;
    control_view[timer_pkg::CTL_RUN] = state_reg.run;
    control_view[timer_pkg::CTL_MATCH_FLAG] = state_reg.match_flag;
    control_view[timer_pkg::CTL_MATCH_IE] = state_reg.match_irq_enable;
    divider_view = {state_reg.mode, state_reg.divider_compare_value};
  end

  always_comb
  begin
    state_next = state_reg;

    // Single-cycle answer: ack rises the cycle after the request and drops the next.
    state_next.ack = bus_request;
    if (bus_request && !we_i)
    begin
      case (word_index)
        timer_pkg::IDX_LOW_MATCH_DATA: state_next.rdata = {24'h00_0000, state_reg.low_match_data};
        timer_pkg::IDX_HIGH_MATCH_DATA:
          state_next.rdata = {24'h00_0000, state_reg.high_match_data};
        timer_pkg::IDX_TIMER_CONTROL: state_next.rdata = {24'h00_0000, control_view};
        timer_pkg::IDX_DIVIDER_AND_MODE: state_next.rdata = {24'h00_0000, divider_view};
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end

    if (bus_write)
    begin
      case (word_index)
        timer_pkg::IDX_LOW_MATCH_DATA: state_next.low_match_data = dat_i[7:0];
        timer_pkg::IDX_HIGH_MATCH_DATA: state_next.high_match_data = dat_i[7:0];
        timer_pkg::IDX_TIMER_CONTROL:
        begin
          state_next.soft_irq_flag = dat_i[timer_pkg::CTL_SOFT_FLAG];
          state_next.soft_irq_enable = dat_i[timer_pkg::CTL_SOFT_ENABLE];
          state_next.clock_source_select = dat_i[timer_pkg::CTL_CLOCK_SOURCE_SELECT_LSB +: 2];
          state_next.run = dat_i[timer_pkg::CTL_RUN];
          state_next.match_flag = dat_i[timer_pkg::CTL_MATCH_FLAG];
          state_next.match_irq_enable = dat_i[timer_pkg::CTL_MATCH_IE];
        end
        timer_pkg::IDX_DIVIDER_AND_MODE:
        begin
          state_next.mode = dat_i[timer_pkg::DIV_MODE_LSB +: timer_pkg::MODE_WIDTH];
          state_next.divider_compare_value =
            dat_i[timer_pkg::DIV_VALUE_LSB +: timer_pkg::DIV_WIDTH];
        end
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end

    // A hardware set lands after the software write so it is never lost.
    if (wide_mode ? wide_match : low_zero)
    begin
      state_next.match_flag = 1'b1;
    end

    if (!state_reg.run || prescale_match)
    begin
      state_next.prescaler = '0;
    end
    else if (source_tick)
    begin
      state_next.prescaler = state_reg.prescaler + 5'h01;
    end

    // Waveforms change in the same cycle as the counter events that drive them.
    case (timer_pkg::timer_mode_t'(state_reg.mode))
      timer_pkg::MODE_TOGGLE_PWM,
      timer_pkg::MODE_TOGGLE_ONLY,
      timer_pkg::MODE_TOGGLE_TOGGLE:
      begin
        state_next.low_wave = state_reg.low_wave ^ low_hit;
      end
      timer_pkg::MODE_PWM_ONLY,
      timer_pkg::MODE_PWM_PWM:
      begin
        if (low_hit)
        begin
          state_next.low_wave = 1'b0;
        end
        if (low_wrap)
        begin
          state_next.low_wave = 1'b1;
        end
      end
      default: state_next.low_wave = 1'b0;
    endcase
    if (!state_reg.run)
    begin
      state_next.low_wave = 1'b0;
    end

    case (timer_pkg::timer_mode_t'(state_reg.mode))
      timer_pkg::MODE_TIMER_TOGGLE,
      timer_pkg::MODE_TOGGLE_TOGGLE:
      begin
        state_next.high_wave = state_reg.high_wave ^ high_hit;
      end
      timer_pkg::MODE_TOGGLE_PWM,
      timer_pkg::MODE_TIMER_PWM,
      timer_pkg::MODE_PWM_PWM:
      begin
        if (high_hit)
        begin
          state_next.high_wave = 1'b0;
        end
        if (high_wrap)
        begin
          state_next.high_wave = 1'b1;
        end
      end
      default: state_next.high_wave = 1'b0;
    endcase
    if (!high_run)
    begin
      state_next.high_wave = 1'b0;
    end

    state_next.irq = (state_next.match_flag & state_next.match_irq_enable)
                     | (state_next.soft_irq_flag & state_next.soft_irq_enable);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign dat_o = state_reg.rdata;
  assign ack_o = state_reg.ack;
  assign low_waveform_output_o = state_reg.low_wave;
  assign high_waveform_output_o = state_reg.high_wave;
  assign irq_o = state_reg.irq;

endmodule
`default_nettype wire

// >>> pkg/timer_pkg.sv
package timer_pkg;

  // Register indices; the byte address on the bus is the index shifted by two.
  localparam logic [29:0] IDX_LOW_MATCH_DATA = 30'h0000_7f10;
  localparam logic [29:0] IDX_HIGH_MATCH_DATA = 30'h0000_7f11;
  localparam logic [29:0] IDX_TIMER_CONTROL = 30'h0000_7f12;
  localparam logic [29:0] IDX_DIVIDER_AND_MODE = 30'h0000_7f13;
  localparam int unsigned ADDR_LSB = 2;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Field positions of timer_control.
  localparam int unsigned CTL_SOFT_STATE = 7;
  localparam int unsigned CTL_SOFT_FLAG = 6;
  localparam int unsigned CTL_SOFT_ENABLE = 5;
  localparam int unsigned CTL_CLOCK_SOURCE_SELECT_LSB = 3;
  localparam int unsigned CTL_RUN = 2;
  localparam int unsigned CTL_MATCH_FLAG = 1;
  localparam int unsigned CTL_MATCH_IE = 0;

  // Field positions of divider_and_mode_control.
  localparam int unsigned DIV_MODE_LSB = 5;
  localparam int unsigned DIV_VALUE_LSB = 0;
  localparam int unsigned DIV_WIDTH = 5;
  localparam int unsigned MODE_WIDTH = 3;

  typedef enum logic [1:0] {
    CLOCK_SOURCE_SELECT_SYSTEM = 2'h0,
    CLOCK_SOURCE_SELECT_RC = 2'h1,
    CLOCK_SOURCE_SELECT_EXT_A = 2'h2,
    CLOCK_SOURCE_SELECT_EXT_B = 2'h3
  } clock_select_t;

  typedef enum logic [2:0] {
    MODE_TIMER16 = 3'h0,
    MODE_TOGGLE_PWM = 3'h1,
    MODE_PWM_ONLY = 3'h2,
    MODE_TOGGLE_ONLY = 3'h3,
    MODE_TIMER_PWM = 3'h4,
    MODE_TIMER_TOGGLE = 3'h5,
    MODE_PWM_PWM = 3'h6,
    MODE_TOGGLE_TOGGLE = 3'h7
  } timer_mode_t;

endpackage

// >>> verilog/edge_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Brings an oscillator pin into the system clock domain and marks its rising edges.
// The oscillator must run below half the system clock rate or edges are lost.
module edge_sync
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic rise_o
);

  typedef struct packed {
    logic meta;
    logic stable;
    logic prev;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.meta = pin_i;
    state_next.stable = state_reg.meta;
    state_next.prev = state_reg.stable;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rise_o = state_reg.stable & ~state_reg.prev;

endmodule
`default_nettype wire

// >>> verilog/byte_counter.sv
`timescale 1ns/100ps
`default_nettype none

// One counter half with its match buffer.
module byte_counter
#(
  parameter int unsigned W = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic clear_on_match_i,
  input wire logic force_clear_i,
  input wire logic [W-1:0] match_data_i,
  output logic [W-1:0] count_o,
  output logic equal_o,
  output logic hit_o,
  output logic wrap_o,
  output logic zero_o
);

  if (W < 2)
  begin : g_bad_width
    $error("byte_counter needs at least two bits");
  end

  typedef struct packed {
    logic [W-1:0] count;
    logic [W-1:0] match_buf;
  } counter_state_t;

  counter_state_t state_reg;
  counter_state_t state_next;

  assign count_o = state_reg.count;
  assign equal_o = (state_reg.count == state_reg.match_buf);
  assign hit_o = run_i & tick_i & equal_o;
  assign wrap_o = run_i & tick_i & (&state_reg.count);

  always_comb
  begin
    state_next = state_reg;
    zero_o = 1'b0;
    if (!run_i)
    begin
      state_next.count = '0;
      state_next.match_buf = match_data_i;
    end
    else
    begin
      if (force_clear_i)
      begin
        state_next.count = '0;
      end
      else if (tick_i)
      begin
        if (clear_on_match_i && equal_o)
        begin
          state_next.count = '0;
        end
        else
        begin
          state_next.count = state_reg.count + {{(W-1){1'b0}}, 1'b1};
        end
      end
      zero_o = (force_clear_i | tick_i) & (state_next.count == '0);
      if (zero_o)
      begin
        state_next.match_buf = match_data_i;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

endmodule
`default_nettype wire

// >>> sim/dual_byte_timer_pwm_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module dual_byte_timer_pwm_monitor
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic stb_i,
  input wire logic cyc_i,
  input wire logic ack_o,
  input wire logic rc_osc_i,
  input wire logic external_clock_a_i,
  input wire logic external_clock_b_i,
  input wire logic low_waveform_output_o,
  input wire logic high_waveform_output_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Reads are judged in the answer cycle, when the request still stands on the bus.
  logic rd_ctl;
  logic rd_div;
  logic [2:0] mode_seen;
  assign rd_ctl = ack_o && !we_i && (adr_i[31:2] == timer_pkg::IDX_TIMER_CONTROL);
  assign rd_div = ack_o && !we_i && (adr_i[31:2] == timer_pkg::IDX_DIVIDER_AND_MODE);
  assign mode_seen = dat_o[7:5];

  a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in the next cycle");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_soft_state: assert property (rd_ctl |-> dat_o[7] == (dat_o[6] && dat_o[5]))
    else $error("soft state bit wrong");
  a_soft_irq: assert property (rd_ctl && dat_o[6] && dat_o[5] |-> irq_o)
    else $error("soft interrupt not raised");
  a_match_irq: assert property (rd_ctl && dat_o[1] && dat_o[0]
    |-> irq_o ##1 irq_o)
    else $error("match interrupt not held");
  a_stop_quiet: assert property (rd_ctl && !dat_o[2]
    |-> !low_waveform_output_o && !high_waveform_output_o)
    else $error("waveform active while stopped");
  a_low_off: assert property (rd_div && mode_seen inside {3'h0, 3'h4, 3'h5}
    |-> !low_waveform_output_o)
    else $error("low waveform active in a quiet mode");
  a_high_off: assert property (rd_div && mode_seen inside {3'h0, 3'h2, 3'h3}
    |-> !high_waveform_output_o)
    else $error("high waveform active in a quiet mode");

  c_flag_read: cover property (rd_ctl && dat_o[1]);
  c_mode7_high: cover property (rd_div && mode_seen == 3'h7 && high_waveform_output_o);
  c_div_write: cover property (ack_o && we_i && (adr_i[31:2] == timer_pkg::IDX_DIVIDER_AND_MODE));
endmodule

bind dual_byte_timer_pwm dual_byte_timer_pwm_monitor dual_byte_timer_pwm_monitor_i
(
  .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
  .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i), .ack_o(ack_o), .rc_osc_i(rc_osc_i),
  .external_clock_a_i(external_clock_a_i), .external_clock_b_i(external_clock_b_i),
  .low_waveform_output_o(low_waveform_output_o),
  .high_waveform_output_o(high_waveform_output_o), .irq_o(irq_o)
);

`default_nettype wire

// >>> sim/dual_byte_timer_pwm_bench.sv
`timescale 1ns/100ps
`default_nettype none

module dual_byte_timer_pwm_bench;
  localparam logic [29:0] BASE = timer_pkg::IDX_LOW_MATCH_DATA;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] adr_i = 32'h0;
  logic [31:0] dat_i = 32'h0;
  logic we_i = 1'b0;
  logic [3:0] sel_i = 4'h0;
  logic stb_i = 1'b0;
  logic cyc_i = 1'b0;
  logic rc_osc_i = 1'b0;
  logic external_clock_a_i = 1'b0;
  logic external_clock_b_i = 1'b0;
  logic [31:0] dat_o;
  logic ack_o;
  logic low_o;
  logic high_o;
  logic irq_o;
  int failures = 0;
  int n_compared = 0;
  int cyc_n = 0;
  int seed = 60744;
  logic [7:0] regs [4] = '{8'h00, 8'h00, 8'h00, 8'h00};

  dual_byte_timer_pwm dual_byte_timer_pwm_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i),
    .ack_o(ack_o), .rc_osc_i(rc_osc_i), .external_clock_a_i(external_clock_a_i),
    .external_clock_b_i(external_clock_b_i), .low_waveform_output_o(low_o),
    .high_waveform_output_o(high_o), .irq_o(irq_o));

  always #2.5 clk_i = ~clk_i;

  // Oscillator pins with periods of 8, 12 and 16 system clocks, slow enough for the synchroniser.
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    rc_osc_i <= ((cyc_n / 4) % 2) == 1;
    external_clock_a_i <= ((cyc_n / 6) % 2) == 1;
    external_clock_b_i <= ((cyc_n / 8) % 2) == 1;
    if (cyc_n == 60000)
    begin
      failures++;
      $display("MISMATCH %0t run did not finish in time", $time);
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    n_compared++;
    if (got != exp)
    begin
      failures++;
      $display("MISMATCH %0t cycles %0d expected %0d", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] exp_rd(input logic [29:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a >= BASE && a <= BASE + 30'h3)
      v = regs[2'(a - BASE)];
    if (a == BASE + 30'h2)
      v[7] = v[6] & v[5];
    return v;
  endfunction

  task automatic wb(input logic w, input logic [29:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {a, 2'b00};
    dat_i <= {24'h000000, d};
    sel_i <= s;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50)
      chk(32'h0, 32'h1);
    if (w && s[0] && a >= BASE && a <= BASE + 30'h3)
      regs[2'(a - BASE)] = (a == BASE + 30'h2) ? (d & 8'h7f) : d;
  endtask

  task automatic wr(input logic [29:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, 4'hf, r);
  endtask

  task automatic rd(input logic [29:0] a);
    logic [31:0] r;
    wb(1'b0, a, 8'h00, 4'hf, r);
    chk(r, {24'h000000, exp_rd(a)});
  endtask

  function automatic logic sig(input int w);
    return (w == 0) ? low_o : (w == 1) ? high_o : irq_o;
  endfunction

  task automatic wait_lvl(input int w, input logic v);
    int n;
    n = 0;
    @(posedge clk_i);
    while (sig(w) !== v && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000)
      chk(32'h0, 32'h1);
  endtask

  task automatic measure(input int w, input int hi, input int per);
    int t0;
    wait_lvl(w, 1'b0);
    wait_lvl(w, 1'b1);
    t0 = cyc_n;
    wait_lvl(w, 1'b0);
    chk_n(cyc_n - t0, hi);
    wait_lvl(w, 1'b1);
    chk_n(cyc_n - t0, per);
  endtask

  task automatic quiet(input int w);
    logic bad;
    bad = 1'b0;
    repeat (600)
    begin
      @(posedge clk_i);
      if (sig(w) !== 1'b0)
        bad = 1'b1;
    end
    chk({31'h0, bad}, 32'h0);
  endtask

  task automatic cfg(input logic [2:0] m, input logic [4:0] d, input logic [7:0] lo,
                     input logic [7:0] hi, input logic [7:0] ctl);
    wr(BASE + 30'h2, 8'h00);
    wr(BASE, lo);
    wr(BASE + 30'h1, hi);
    wr(BASE + 30'h3, {m, d});
    wr(BASE + 30'h2, ctl);
  endtask

  initial
  begin
    int a;
    int sp;
    int t0;
    logic [7:0] v;
    logic [31:0] r;
    // Low half: 0 quiet, 1 toggle, 2 PWM; high half: 0 quiet, 1 toggle, 2 PWM.
    int lowk [8] = '{0, 1, 2, 1, 0, 0, 2, 1};
    int highk [8] = '{0, 2, 0, 0, 2, 1, 2, 1};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (a = 0; a < 4; a++)
      rd(BASE + 30'(a));
    rd(BASE + 30'h4);
    repeat (12)
    begin
      a = $unsigned($random(seed)) % 4;
      v = 8'($random(seed));
      wr(BASE + 30'(a), (a == 2) ? (v & 8'h7b) : v);
      rd(BASE + 30'(a));
      chk({31'h0, irq_o},
          {31'h0, (regs[2][6] & regs[2][5]) | (regs[2][1] & regs[2][0])});
    end
    wb(1'b1, BASE, ~regs[0], 4'he, r);
    rd(BASE);
    wr(BASE + 30'h4, 8'ha5);
    rd(BASE + 30'h4);
    wr(BASE + 30'h2, 8'h60);
    chk({31'h0, irq_o}, 32'h1);
    rd(BASE + 30'h2);
    wr(BASE + 30'h2, 8'h20);
    chk({31'h0, irq_o}, 32'h0);
    for (a = 0; a < 8; a++)
    begin
      cfg(3'(a), 5'h02, 8'h04, 8'h09, 8'h04);
      if (lowk[a] == 0)
        quiet(0);
      else
        measure(0, 15, (lowk[a] == 1) ? 30 : 768);
      if (highk[a] == 0)
        quiet(1);
      else
        measure(1, 10, (highk[a] == 1) ? 20 : 256);
      rd(BASE + 30'h3);
    end
    for (a = 0; a < 4; a++)
    begin
      sp = (a == 0) ? 1 : (a == 1) ? 8 : (a == 2) ? 12 : 16;
      cfg(3'h3, 5'h01, 8'h02, 8'h00, {3'b000, 2'(a), 3'b100});
      measure(0, 6 * sp, 12 * sp);
    end
    cfg(3'h3, 5'h01, 8'h02, 8'h00, 8'h04);
    measure(0, 6, 12);
    wr(BASE, 8'h06);
    measure(0, 14, 28);
    wr(BASE + 30'h2, 8'h00);
    quiet(0);
    // The stopping write may meet a hardware flag set, so clear the flag again while stopped.
    wr(BASE + 30'h2, 8'h00);
    rd(BASE + 30'h2);
    cfg(3'h0, 5'h01, 8'h05, 8'h01, 8'h05);
    wait_lvl(2, 1'b1);
    t0 = cyc_n;
    regs[2][1] = 1'b1;
    rd(BASE + 30'h2);
    wr(BASE + 30'h2, 8'h05);
    chk({31'h0, irq_o}, 32'h0);
    wait_lvl(2, 1'b1);
    chk_n(cyc_n - t0, 524);
    end_sim();
  end
endmodule

`default_nettype wire
